/* verilog/apc_pkg.sv */
// Package: constants, register map and types of the post-conversion compute unit
package apc_pkg;
	// ==================== Register map
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CP = 8'h04;
	localparam logic [7:0] OFS_RPT = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_ACC = 8'h10;
	localparam logic [7:0] OFS_CNT = 8'h14;
	localparam logic [7:0] OFS_FLT = 8'h18;
	localparam logic [7:0] OFS_RES = 8'h1C;
	localparam logic [7:0] OFS_THR = 8'h20;
	// ==================== Field positions
	localparam int CTL_MODE = 0;
	localparam int CTL_SHIFT = 4;
	localparam int CTL_DOUBLE_SAMPLE_ENABLE = 8;
	localparam int CTL_CLR = 12;
	localparam int CTL_RC = 13;
	localparam int CP_EN = 0;
	localparam int CP_RDY = 1;
	localparam int ST_OVF = 0;
	localparam int ST_DONE = 1;
	localparam int ST_THR = 2;
	localparam int RES_PREV = 16;
	localparam int THR_UP = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==================== Limits and timing
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic signed [19:0] ACC_MAX = 20'sh3FFFF;
	localparam logic signed [19:0] ACC_MIN = -20'sh40000;
	localparam int CLK_MHZ = 40;
	localparam int CP_STARTUP_NS = 1000;
	localparam logic [7:0] CP_STARTUP_CYC = 8'((CP_STARTUP_NS * CLK_MHZ + 999) / 1000);
	localparam int RC_PERIOD_NS = 500;
	localparam int CLR_RC_CLOCKS = 5;
	localparam logic [7:0] CLR_RC_CYC =
		8'((CLR_RC_CLOCKS * RC_PERIOD_NS * CLK_MHZ + 999) / 1000);
	// ==================== Types
	typedef enum logic [2:0] {
		MODE_BASIC = 3'h0,
		MODE_ACC = 3'h1,
		MODE_AVG = 3'h2,
		MODE_BURST = 3'h3,
		MODE_LPF = 3'h4
	} apc_mode_t;
	typedef enum logic [1:0] {
		CP_OFF = 2'h0,
		CP_WAIT = 2'h1,
		CP_READY = 2'h2
	} apc_cp_t;
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} apc_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} apc_axi_rsp_t;
	typedef struct packed {
		logic valid;
		logic [11:0] data;
	} apc_conv_t;
	typedef struct packed {
		apc_axi_rsp_t ax;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [2:0] mode;
		logic [2:0] shift;
		logic double_sample_enable;
		logic clr;
		logic rcsel;
		logic [7:0] clr_cnt;
		logic cp_en;
		apc_cp_t cp_st;
		logic [7:0] cp_cnt;
		logic cp_rdy;
		logic [7:0] rpt;
		logic ovf;
		logic done;
		logic thr;
		logic [18:0] acc;
		logic [7:0] cnt;
		logic [15:0] flt;
		logic [11:0] res;
		logic [11:0] prev;
		logic phase;
		logic [15:0] lth;
		logic [15:0] uth;
		logic retrig;
		logic thr_evt;
	} apc_state_t;
	localparam apc_state_t APC_RST = '{
		ax: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
		cp_st: CP_OFF,
		default: '0
	};
endpackage

/* verilog/apc_compute.sv */
// Post-conversion compute unit: accumulator, averager, filter, charge pump and AXI4-Lite registers
// Overview of operation
// - Enabling the charge pump waits a start-up interval, then raises pump ready.
// - Three-bit mode field selects Basic, Accumulate, Average, Burst Average, Low-Pass.
// - Basic keeps accumulator and count; tests every sample; double sample needs both.
// - Accumulate adds each sample, count saturates at 0xFF, done and test each sample.
// - Operand is the result, or result minus previous result when double sampling.
// - Average clears accumulator and count at trigger when count reached target.
// - Average, Burst and Low-Pass test only when count reaches repeat target.
// - Burst clears at trigger, then retriggers until count equals target, then tests.
// - Low-Pass sets accumulator to sample plus accumulator minus shifted accumulator.
// - Low-Pass tests every sample once repeat target samples were taken.
// - Threshold flag is set whenever a performed test is true.
// - Accumulator clear wipes accumulator, overflow and count, then self-clears.
// - Under the RC clock the clear lasts five RC clock cycles.
// - Accumulator register is 24 bits holding 18-bit value plus extended sign.
// - Accumulation beyond 262143 sets the overflow flag.
// - Accumulator shifted right by shift select goes into signed filtered result.
// - Filtered result that does not fit sets the overflow flag.
// - Average and Burst use a logical right shift.
// - Error is compared with upper and lower thresholds as signed values.
// - A set overflow flag makes the threshold test fire regardless.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module apc_compute import apc_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire apc_axi_req_t s_axi_req,
	output apc_axi_rsp_t s_axi_rsp,
	// Converter core
	input wire logic conv_trigger,
	input wire apc_conv_t conv,
	output logic retrigger_req,
	output logic threshold_event,
	// Charge pump
	output logic charge_pump_on,
	output logic charge_pump_ready
);
	apc_state_t s_r;
	apc_state_t s_nxt;
	logic conv_go;

	// ==================== Register read mux
	function automatic logic [33:0] rd_val(input apc_state_t st, input logic [7:0] a);
		logic [31:0] d;
		logic [1:0] e;
		d = '0;
		e = RESP_OKAY;
		case (a)
			OFS_CTRL: begin
				d[CTL_MODE +: 3] = st.mode;
				d[CTL_SHIFT +: 3] = st.shift;
				d[CTL_DOUBLE_SAMPLE_ENABLE] = st.double_sample_enable;
				d[CTL_CLR] = st.clr;
				d[CTL_RC] = st.rcsel;
			end
			OFS_CP: begin
				d[CP_EN] = st.cp_en;
				d[CP_RDY] = st.cp_rdy;
			end
			OFS_RPT: d[7:0] = st.rpt;
			OFS_STAT: begin
				d[ST_OVF] = st.ovf;
				d[ST_DONE] = st.done;
				d[ST_THR] = st.thr;
			end
			OFS_ACC: d[23:0] = {{5{st.acc[18]}}, st.acc};
			OFS_CNT: d[7:0] = st.cnt;
			OFS_FLT: d[15:0] = st.flt;
			OFS_RES: begin
				d[11:0] = st.res;
				d[RES_PREV +: 12] = st.prev;
			end
			OFS_THR: d = {st.uth, st.lth};
			default: e = RESP_SLVERR;
		endcase
		return {e, d};
	endfunction

	// ==================== Shifted accumulator
	function automatic logic [19:0] shifted(input logic [18:0] a, input logic [2:0] sh,
		input logic [2:0] md);
		if (md == MODE_AVG || md == MODE_BURST) begin
			return {1'b0, a} >> sh;
		end
		return 20'($signed({a[18], a}) >>> sh);
	endfunction

	assign conv_go = conv.valid && !s_r.clr && (!s_r.double_sample_enable || s_r.phase);

	// ==================== Next state
	always_comb begin
		logic [33:0] rv;
		logic [31:0] wm;
		logic [31:0] wv;
		logic signed [19:0] op;
		logic signed [19:0] a;
		logic signed [19:0] sum;
		logic [19:0] sv;
		logic [7:0] cn;
		logic test;
		logic hit;
		logic signed [15:0] err;
		rv = '0;
		wm = '0;
		wv = '0;
		op = '0;
		a = '0;
		sum = '0;
		sv = '0;
		cn = '0;
		test = 1'b0;
		hit = 1'b0;
		err = '0;
		s_nxt = s_r;
		s_nxt.retrig = 1'b0;
		s_nxt.thr_evt = 1'b0;
		// AXI channels
		if (s_r.ax.awready && s_axi_req.awvalid) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_req.awaddr;
			s_nxt.ax.awready = 1'b0;
		end
		if (s_r.ax.wready && s_axi_req.wvalid) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_req.wdata;
			s_nxt.wstrb = s_axi_req.wstrb;
			s_nxt.ax.wready = 1'b0;
		end
		if (s_r.ax.bvalid && s_axi_req.bready) begin
			s_nxt.ax.bvalid = 1'b0;
			s_nxt.ax.awready = 1'b1;
			s_nxt.ax.wready = 1'b1;
		end
		if (s_r.ax.arready && s_axi_req.arvalid) begin
			rv = rd_val(s_r, s_axi_req.araddr);
			s_nxt.ax.arready = 1'b0;
			s_nxt.ax.rvalid = 1'b1;
			s_nxt.ax.rdata = rv[31:0];
			s_nxt.ax.rresp = rv[33:32];
		end
		if (s_r.ax.rvalid && s_axi_req.rready) begin
			s_nxt.ax.rvalid = 1'b0;
			s_nxt.ax.arready = 1'b1;
		end
		// Register write
		if (s_r.aw_got && s_r.w_got && !s_r.ax.bvalid) begin
			rv = rd_val(s_r, s_r.awaddr);
			for (int i = 0; i < 4; i++) begin
				wm[i*8 +: 8] = {8{s_r.wstrb[i]}};
			end
			wv = (rv[31:0] & ~wm) | (s_r.wdata & wm);
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.ax.bvalid = 1'b1;
			s_nxt.ax.bresp = rv[33:32];
			case (s_r.awaddr)
				OFS_CTRL: begin
					s_nxt.mode = wv[CTL_MODE +: 3];
					s_nxt.shift = wv[CTL_SHIFT +: 3];
					s_nxt.double_sample_enable = wv[CTL_DOUBLE_SAMPLE_ENABLE];
					s_nxt.rcsel = wv[CTL_RC];
					if (wv[CTL_CLR] && !s_r.clr) begin
						s_nxt.clr = 1'b1;
						s_nxt.clr_cnt = wv[CTL_RC] ? CLR_RC_CYC - 8'h01 : 8'h00;
					end
				end
				OFS_CP: s_nxt.cp_en = wv[CP_EN];
				OFS_RPT: s_nxt.rpt = wv[7:0];
				OFS_STAT: begin
					wv = s_r.wdata & wm;
					s_nxt.ovf = s_r.ovf & ~wv[ST_OVF];
					s_nxt.done = s_r.done & ~wv[ST_DONE];
					s_nxt.thr = s_r.thr & ~wv[ST_THR];
				end
				OFS_ACC: s_nxt.acc = wv[18:0];
				OFS_CNT: s_nxt.cnt = wv[7:0];
				OFS_THR: begin
					s_nxt.lth = wv[15:0];
					s_nxt.uth = wv[THR_UP +: 16];
				end
				default: begin
				end
			endcase
		end
		// Charge pump start-up
		case (s_r.cp_st)
			CP_OFF: begin
				s_nxt.cp_cnt = 8'h00;
				if (s_r.cp_en) begin
					s_nxt.cp_st = CP_WAIT;
				end
			end
			CP_WAIT: begin
				if (!s_r.cp_en) begin
					s_nxt.cp_st = CP_OFF;
				end else if (s_r.cp_cnt == CP_STARTUP_CYC - 8'h01) begin
					s_nxt.cp_st = CP_READY;
					s_nxt.cp_rdy = 1'b1;
				end else begin
					s_nxt.cp_cnt = s_r.cp_cnt + 8'h01;
				end
			end
			CP_READY: begin
				if (!s_r.cp_en) begin
					s_nxt.cp_st = CP_OFF;
				end
			end
			default: s_nxt.cp_st = CP_OFF;
		endcase
		if (s_nxt.cp_st != CP_READY) begin
			s_nxt.cp_rdy = 1'b0;
		end
		// Accumulator clear
		if (s_r.clr) begin
			s_nxt.acc = '0;
			s_nxt.cnt = '0;
			s_nxt.ovf = 1'b0;
			if (s_r.clr_cnt == 8'h00) begin
				s_nxt.clr = 1'b0;
			end else begin
				s_nxt.clr_cnt = s_r.clr_cnt - 8'h01;
			end
		end else if (conv_trigger) begin
			if (s_r.mode == MODE_BURST || (s_r.mode == MODE_AVG && s_r.cnt >= s_r.rpt)) begin
				s_nxt.acc = '0;
				s_nxt.cnt = '0;
			end
		end
		// Conversion result
		if (conv.valid && !s_r.clr) begin
			s_nxt.res = conv.data;
			s_nxt.prev = s_r.res;
			s_nxt.phase = s_r.double_sample_enable ? !s_r.phase : 1'b0;
		end
		if (conv_go) begin
			if (s_r.double_sample_enable) begin
				op = 20'($signed({1'b0, conv.data}) - $signed({1'b0, s_r.res}));
			end else begin
				op = {8'h00, conv.data};
			end
			a = {s_nxt.acc[18], s_nxt.acc};
			cn = (s_nxt.cnt == CNT_MAX) ? CNT_MAX : s_nxt.cnt + 8'h01;
			s_nxt.done = 1'b1;
			err = op[15:0];
			if (s_r.mode == MODE_BASIC) begin
				test = 1'b1;
			end else begin
				if (s_r.mode == MODE_LPF) begin
					sum = op + a - $signed(shifted(s_nxt.acc, s_r.shift, s_r.mode));
				end else begin
					sum = op + a;
				end
				if (sum > ACC_MAX || sum < ACC_MIN) begin
					s_nxt.ovf = 1'b1;
				end
				s_nxt.acc = sum[18:0];
				s_nxt.cnt = cn;
				sv = shifted(sum[18:0], s_r.shift, s_r.mode);
				if (sv[19:15] != {5{sv[15]}}) begin
					s_nxt.ovf = 1'b1;
				end
				s_nxt.flt = sv[15:0];
				err = sv[15:0];
				test = (s_r.mode == MODE_ACC) || (cn >= s_r.rpt);
				if (s_r.mode == MODE_BURST && cn < s_r.rpt) begin
					s_nxt.retrig = 1'b1;
				end
			end
			hit = (err > $signed(s_r.uth)) || (err < $signed(s_r.lth));
			if (test && (hit || s_nxt.ovf)) begin
				s_nxt.thr = 1'b1;
				s_nxt.thr_evt = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= APC_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==================== Outputs
	assign s_axi_rsp = s_r.ax;
	assign retrigger_req = s_r.retrig;
	assign threshold_event = s_r.thr_evt;
	assign charge_pump_on = s_r.cp_en;
	assign charge_pump_ready = s_r.cp_rdy;

	// ==================== Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	localparam int CLR_MAX = 110;
	sequence seq_clr_start;
		!s_r.clr ##1 s_r.clr;
	endsequence
	sequence seq_wr_both;
		s_r.aw_got && s_r.w_got && !s_r.ax.bvalid;
	endsequence
	property p_cp_ready;
		$rose(s_r.cp_st == CP_WAIT) |-> !s_r.cp_rdy [*8];
	endproperty
	a_cp_ready: assert property (p_cp_ready) else $error("pump ready too early");
	property p_clr_done;
		seq_clr_start |-> ##[1:CLR_MAX] !s_r.clr;
	endproperty
	a_clr_done: assert property (p_clr_done) else $error("clear never ends");
	property p_basic_hold;
		conv_go && s_r.mode == MODE_BASIC && !conv_trigger |=> $stable(s_r.acc) && $stable(s_r.cnt);
	endproperty
	a_basic_hold: assert property (p_basic_hold) else $error("basic changed acc");
	property p_cnt_sat;
		conv_go && s_r.mode == MODE_ACC && s_r.cnt == CNT_MAX |=> s_r.cnt == CNT_MAX;
	endproperty
	a_cnt_sat: assert property (p_cnt_sat) else $error("count wrapped");
	property p_ovf_thr;
		conv_go && s_r.mode == MODE_ACC ##1 s_r.ovf |-> s_r.thr;
	endproperty
	a_ovf_thr: assert property (p_ovf_thr) else $error("overflow without threshold");
	property p_retrig;
		s_r.retrig |-> s_r.mode == MODE_BURST && s_r.cnt < s_r.rpt;
	endproperty
	a_retrig: assert property (p_retrig) else $error("bad retrigger");
	property p_test_gate;
		s_r.thr_evt && s_r.mode inside {MODE_AVG, MODE_BURST, MODE_LPF} |-> s_r.cnt >= s_r.rpt;
	endproperty
	a_test_gate: assert property (p_test_gate) else $error("test before target");
	property p_flt;
		conv_go && s_r.mode == MODE_ACC && !conv_trigger ##1 !s_r.ovf
			|-> s_r.flt == 16'(shifted(s_r.acc, s_r.shift, s_r.mode));
	endproperty
	a_flt: assert property (p_flt) else $error("filtered result stale");
	property p_bresp;
		seq_wr_both |=> s_r.ax.bvalid;
	endproperty
	a_bresp: assert property (p_bresp) else $error("no write response");
endmodule

/* bench/apc_conv_model.sv */
// Converter core model: answers each start seen while idle with one conversion after a set latency
`timescale 1ns/1ps
module apc_conv_model import apc_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Requests and sample source
	input wire logic start,
	input wire logic [11:0] sample,
	input wire logic [3:0] lat,
	// Result to the compute unit
	output apc_conv_t conv
);
	logic busy_r;
	logic [3:0] wait_r;
	// ====================
	// Conversion sequencer
	always_ff @(posedge aclk) begin
		conv.valid <= 1'b0;
		// Data toggles outside the valid pulse
		conv.data <= ~conv.data;
		if (!aresetn) begin
			busy_r <= 1'b0;
			wait_r <= '0;
			conv <= '0;
		end else if (busy_r) begin
			wait_r <= wait_r - 4'h1;
			if (wait_r == 4'h0) begin
				busy_r <= 1'b0;
				conv.valid <= 1'b1;
				conv.data <= sample;
			end
		end else if (start) begin
			busy_r <= 1'b1;
			wait_r <= lat;
		end
	end
endmodule

/* bench/testbench.sv */
// Testbench: register and conversion scenarios for the compute unit
`timescale 1ns/1ps
module testbench import apc_pkg::*;;
	logic aclk;
	logic aresetn;
	logic conv_trigger;
	logic go;
	logic retrigger_req;
	logic threshold_event;
	logic charge_pump_on;
	logic charge_pump_ready;
	logic [11:0] smp;
	logic [3:0] lat;
	logic [31:0] rdat;
	logic [1:0] rrsp;
	logic [1:0] wrsp;
	int retrigs = 0;
	apc_axi_req_t req;
	apc_axi_rsp_t rsp;
	apc_conv_t conv;
	int miscompares;
	int cmp_count;
	int cyc = 0;
	int t0;

	apc_compute DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
		.conv_trigger(conv_trigger), .conv(conv), .retrigger_req(retrigger_req),
		.threshold_event(threshold_event), .charge_pump_on(charge_pump_on),
		.charge_pump_ready(charge_pump_ready));
	apc_conv_model u_core (.aclk(aclk), .aresetn(aresetn), .start(go | retrigger_req),
		.sample(smp), .lat(lat), .conv(conv));

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;
	// Retrigger pulses seen by the converter model
	always @(posedge aclk) begin
		if (retrigger_req === 1'b1) retrigs <= retrigs + 1;
	end

	// ====================
	// Bus and conversion tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		wrsp = rsp.bresp;
		req.bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		rdat = rsp.rdata;
		rrsp = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rdat, e);
	endtask
	task automatic cv(input logic [11:0] s, input logic t);
		smp <= s;
		conv_trigger <= t;
		go <= 1'b1;
		@(posedge aclk);
		conv_trigger <= 1'b0;
		go <= 1'b0;
		do @(posedge aclk); while (conv.valid !== 1'b1);
		@(posedge aclk);
	endtask
	task automatic give_verdict;
		if (miscompares == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		give_verdict();
	end

	// ====================
	// Scenarios
	initial begin
		aresetn = 1'b0;
		req = '0;
		conv_trigger = 1'b0;
		go = 1'b0;
		smp = '0;
		lat = 4'h1;
		miscompares = 0;
		cmp_count = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(OFS_CTRL, 32'h0);
		rd(8'h24);
		chk({30'h0, rrsp}, {30'h0, RESP_SLVERR});
		wr(8'h24, 32'h1);
		chk({30'h0, wrsp}, {30'h0, RESP_SLVERR});
		wr(OFS_CP, 32'h1);
		chk({30'h0, wrsp}, {30'h0, RESP_OKAY});
		rc(OFS_CP, 32'h1);
		while (charge_pump_ready !== 1'b1) @(posedge aclk);
		rc(OFS_CP, 32'h3);
		chk({31'h0, charge_pump_on}, 32'h1);
		// Basic mode, signed window of plus and minus 0x200
		wr(OFS_THR, 32'h0200FE00);
		cv(12'h100, 1'b1);
		rc(OFS_STAT, 32'h2);
		wr(OFS_STAT, 32'h7);
		cv(12'h300, 1'b1);
		rc(OFS_STAT, 32'h6);
		rc(OFS_ACC, 32'h0);
		rc(OFS_CNT, 32'h0);
		wr(OFS_CTRL, 32'h21);
		repeat (3) cv(12'h800, 1'b0);
		rc(OFS_ACC, 32'h1800);
		rc(OFS_CNT, 32'h3);
		rc(OFS_FLT, 32'h600);
		wr(OFS_CNT, 32'hFE);
		repeat (2) cv(12'h800, 1'b0);
		rc(OFS_CNT, 32'hFF);
		rc(OFS_ACC, 32'h2800);
		// Widest window: only overflow can fire
		wr(OFS_THR, 32'h7FFF8000);
		wr(OFS_ACC, 32'h3FFFF);
		wr(OFS_STAT, 32'h7);
		cv(12'h001, 1'b0);
		rc(OFS_STAT, 32'h7);
		wr(OFS_THR, 32'h0200FE00);
		wr(OFS_CTRL, 32'h3021);
		t0 = cyc;
		rc(OFS_CTRL, 32'h3021);
		do rd(OFS_CTRL); while (rdat[CTL_CLR] !== 1'b0);
		chk({31'h0, cyc - t0 > CLR_RC_CYC - 8}, 32'h1);
		rc(OFS_ACC, 32'h0);
		rc(OFS_CNT, 32'h0);
		rc(OFS_STAT, 32'h6);
		wr(OFS_CTRL, 32'h101);
		cv(12'h200, 1'b0);
		cv(12'h100, 1'b0);
		rc(OFS_ACC, 32'hFFFF00);
		rc(OFS_CNT, 32'h1);
		rc(OFS_RES, 32'h02000100);
		wr(OFS_CTRL, 32'h2);
		wr(OFS_RPT, 32'h2);
		rc(OFS_RPT, 32'h2);
		wr(OFS_ACC, 32'h0);
		wr(OFS_CNT, 32'h0);
		wr(OFS_STAT, 32'h7);
		cv(12'h300, 1'b1);
		rc(OFS_STAT, 32'h2);
		cv(12'h300, 1'b1);
		rc(OFS_STAT, 32'h6);
		cv(12'h100, 1'b1);
		rc(OFS_ACC, 32'h100);
		rc(OFS_CNT, 32'h1);
		wr(OFS_CTRL, 32'h23);
		wr(OFS_RPT, 32'h4);
		lat <= 4'h7;
		cv(12'h300, 1'b1);
		while (threshold_event !== 1'b1) @(posedge aclk);
		@(posedge aclk);
		rc(OFS_ACC, 32'hC00);
		rc(OFS_CNT, 32'h4);
		rc(OFS_FLT, 32'h300);
		chk(retrigs, 32'h3);
		// Negative accumulator: logical shift must not copy the sign
		wr(OFS_CTRL, 32'h42);
		wr(OFS_ACC, 32'h40000);
		cv(12'h100, 1'b0);
		rc(OFS_ACC, 32'hFC0100);
		rc(OFS_FLT, 32'h4010);
		wr(OFS_CTRL, 32'h14);
		wr(OFS_RPT, 32'h1);
		wr(OFS_ACC, 32'h0);
		wr(OFS_CNT, 32'h0);
		wr(OFS_STAT, 32'h7);
		cv(12'h100, 1'b0);
		cv(12'h100, 1'b0);
		rc(OFS_ACC, 32'h180);
		rc(OFS_FLT, 32'hC0);
		rc(OFS_STAT, 32'h2);
		cv(12'hF00, 1'b0);
		rc(OFS_STAT, 32'h6);
		give_verdict();
	end
endmodule
